// *** rtl/wdt_regs.vh ***
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// counter and compare widths
`define WDT_CNT_W        24
// divide-by-four prescaler terminal count
`define WDT_PRESCALE_MAX 2'h3
// lowest value ever loaded into the counter
`define WDT_MIN_LOAD     24'h0000ff
// feed sequence bytes
`define WDT_FEED_FIRST   8'haa
`define WDT_FEED_SECOND  8'h55
// reset values
`define WDT_RELOAD_RST   24'h0000ff
`define WDT_COUNT_RST    24'h0000ff
`define WDT_WARN_RST     24'h000000
`define WDT_WINDOW_RST   24'hffffff

`endif

// *** rtl/tick_sync.v ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// two-flop synchroniser with rising-edge pulse
module tick_sync (
  input  wire mclk,
  input  wire rst,
  input  wire async_in,
  output reg  rise_pulse
);

  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  always @(posedge mclk) begin
    if (rst) begin
      meta_reg   <= 1'b0;
      sync_reg   <= 1'b0;
      last_reg   <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      meta_reg   <= async_in;
      sync_reg   <= meta_reg;
      last_reg   <= sync_reg;
      rise_pulse <= sync_reg & ~last_reg;
    end
  end

endmodule // tick_sync

`default_nettype wire

// *** rtl/windowed_watchdog_timer.v ***
// Operation
// - 24-bit counter, one decrement per four ticks
// - reload below 0xFF loads 0xFF instead
// - feed 0xAA then 0x55 reloads, starts counting
// - run enable cannot be cleared once set
// - enabling locks count clock source selection
// - only reset disables a running timer
// - decrement with counter already at zero, unfed, raises event
// - feed above window value raises event
// - reset enable requests chip reset per event
// - timeout flag survives watchdog reset until cleared
// - warning raised when counter equals warning value
// - bad feed sequence while enabled raises reset
// - reload writes optionally refused until warning reached
// - running timer keeps watchdog oscillator powered
// - reload writes reach the reload register in one cycle
// - mode writes take effect after valid feed
// - reset enable bit is set only
// - counter captured then presented for readback
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.vh"

module windowed_watchdog_timer (
  input  wire        mclk,
  input  wire        rst,
  input  wire        por_rst,
  input  wire        count_clock,
  input  wire        mode_wr,
  input  wire        mode_run_enable_in,
  input  wire        mode_reset_en_in,
  input  wire        mode_protect_in,
  input  wire        reload_wr,
  input  wire [23:0] reload_data,
  input  wire        feed_wr,
  input  wire [7:0]  feed_data,
  input  wire        window_wr,
  input  wire [23:0] window_data,
  input  wire        warning_wr,
  input  wire [23:0] warning_data,
  input  wire        readback_rd,
  input  wire        timeout_flag_clear,
  input  wire        warning_clear,
  input  wire        osc_power_down_req,
  output reg         run_enable_bit,
  output reg         reset_on_timeout_enable,
  output reg         reload_protect,
  output wire        clock_source_lock,
  output wire        osc_power_down,
  output reg         timeout_flag,
  output reg         warning_flag,
  output reg         watchdog_event,
  output reg         chip_reset_req,
  output reg  [23:0] reload_constant,
  output reg  [23:0] window_compare,
  output reg  [23:0] warning_compare,
  output reg  [23:0] counter_readback
);

  // ===================================================================
  // helpers
  function [23:0] clamp_load;
    input [23:0] v;
    begin
      clamp_load = (v < `WDT_MIN_LOAD) ? `WDT_MIN_LOAD : v;
    end
  endfunction

  // zero compare value means warning disabled
  function warn_match;
    input [23:0] cnt;
    input [23:0] cmp;
    begin
      warn_match = (cmp != 24'h000000) && (cnt == cmp);
    end
  endfunction

  // ===================================================================
  // state
  localparam [0:0] FS_IDLE      = 1'b0;
  localparam [0:0] FS_GOT_FIRST = 1'b1;

  wire        tick;
  reg  [1:0]  presc_reg;
  reg  [23:0] count_reg;
  reg  [23:0] capture_reg;
  reg         counting_reg;
  reg         fs_reg;
  reg         warn_reached_reg;
  reg         pend_run_reg;
  reg         pend_rst_reg;
  reg         pend_prot_reg;

  tick_sync u_tick_sync (
    .mclk       (mclk),
    .rst        (rst),
    .async_in   (count_clock),
    .rise_pulse (tick)
  );

  wire other_access = mode_wr | reload_wr | window_wr | warning_wr | readback_rd;
  wire feed_first   = feed_wr && (feed_data == `WDT_FEED_FIRST);
  wire feed_done    = (fs_reg == FS_GOT_FIRST) && feed_wr &&
                      (feed_data == `WDT_FEED_SECOND) && !other_access;
  wire feed_bad     = (fs_reg == FS_GOT_FIRST) &&
                      ((feed_wr && (feed_data != `WDT_FEED_SECOND)) || other_access);
  wire dec_now      = counting_reg && tick && (presc_reg == `WDT_PRESCALE_MAX);
  wire early_feed   = feed_done && counting_reg && (count_reg > window_compare);
  // a feed landing on the final decrement rescues the count
  wire expire       = dec_now && (count_reg == 24'h000000) && !feed_done;
  wire bad_event    = feed_bad && run_enable_bit;
  wire event_now    = expire | early_feed | bad_event;
  wire good_feed    = feed_done && !early_feed;
  wire reload_ok    = !reload_protect || warn_reached_reg;
  wire warn_hit     = counting_reg && warn_match(count_reg, warning_compare);

  assign clock_source_lock = run_enable_bit;
  assign osc_power_down    = osc_power_down_req & ~counting_reg;

  // ===================================================================
  // feed sequencer
  always @(posedge mclk) begin
    if (rst) begin
      fs_reg <= FS_IDLE;
    end else begin
      case (fs_reg)
        FS_IDLE: begin
          if (feed_first && !other_access) begin
            fs_reg <= FS_GOT_FIRST;
          end
        end
        FS_GOT_FIRST: begin
          fs_reg <= (feed_bad && feed_first && !other_access) ? FS_GOT_FIRST : FS_IDLE;
        end
        default: begin
          fs_reg <= FS_IDLE;
        end
      endcase
    end
  end

  // ===================================================================
  // mode control, held until a valid feed
  always @(posedge mclk) begin
    if (rst) begin
      pend_run_reg            <= 1'b0;
      pend_rst_reg            <= 1'b0;
      pend_prot_reg           <= 1'b0;
      run_enable_bit          <= 1'b0;
      reset_on_timeout_enable <= 1'b0;
      reload_protect          <= 1'b0;
    end else begin
      if (mode_wr) begin
        pend_run_reg  <= pend_run_reg | mode_run_enable_in;
        pend_rst_reg  <= pend_rst_reg | mode_reset_en_in;
        pend_prot_reg <= mode_protect_in;
      end
      if (good_feed) begin
        run_enable_bit          <= run_enable_bit | pend_run_reg;
        reset_on_timeout_enable <= reset_on_timeout_enable | pend_rst_reg;
        reload_protect          <= pend_prot_reg;
      end
    end
  end

  // ===================================================================
  // compare and reload registers
  always @(posedge mclk) begin
    if (rst) begin
      reload_constant <= `WDT_RELOAD_RST;
      window_compare  <= `WDT_WINDOW_RST;
      warning_compare <= `WDT_WARN_RST;
    end else begin
      if (reload_wr && reload_ok) begin
        reload_constant <= reload_data;
      end
      if (window_wr) begin
        window_compare <= window_data;
      end
      if (warning_wr) begin
        warning_compare <= warning_data;
      end
    end
  end

  // ===================================================================
  // prescaler and down counter
  always @(posedge mclk) begin
    if (rst) begin
      presc_reg        <= 2'h0;
      count_reg        <= `WDT_COUNT_RST;
      counting_reg     <= 1'b0;
      warn_reached_reg <= 1'b0;
    end else begin
      if (good_feed) begin
        count_reg        <= clamp_load(reload_constant);
        presc_reg        <= 2'h0;
        warn_reached_reg <= 1'b0;
        if (run_enable_bit | pend_run_reg) begin
          counting_reg <= 1'b1;
        end
      end else if (expire) begin
        count_reg <= clamp_load(reload_constant);
        presc_reg <= 2'h0;
      end else begin
        if (counting_reg && tick) begin
          presc_reg <= presc_reg + 2'h1;
        end
        if (dec_now) begin
          count_reg <= count_reg - 24'h000001;
        end
        if (warn_hit) begin
          warn_reached_reg <= 1'b1;
        end
      end
    end
  end

  // ===================================================================
  // events, flags and readback
  always @(posedge mclk) begin
    if (rst) begin
      watchdog_event   <= 1'b0;
      chip_reset_req   <= 1'b0;
      warning_flag     <= 1'b0;
      capture_reg      <= `WDT_COUNT_RST;
      counter_readback <= `WDT_COUNT_RST;
    end else begin
      watchdog_event   <= event_now;
      chip_reset_req   <= (event_now && reset_on_timeout_enable) || bad_event;
      capture_reg      <= count_reg;
      counter_readback <= capture_reg;
      if (warn_hit && !warn_reached_reg) begin
        warning_flag <= 1'b1;
      end else if (warning_clear) begin
        warning_flag <= 1'b0;
      end
    end
  end

  // flag only cleared by power-on reset or software
  always @(posedge mclk) begin
    if (por_rst) begin
      timeout_flag <= 1'b0;
    end else if (event_now) begin
      timeout_flag <= 1'b1;
    end else if (timeout_flag_clear) begin
      timeout_flag <= 1'b0;
    end
  end

endmodule // windowed_watchdog_timer

`default_nettype wire

// *** verif/wdt_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// port properties of the watchdog
module wdt_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic por_rst,
  input wire logic mode_wr,
  input wire logic feed_wr,
  input wire logic timeout_flag_clear,
  input wire logic warning_clear,
  input wire logic run_enable_bit,
  input wire logic reset_on_timeout_enable,
  input wire logic clock_source_lock,
  input wire logic osc_power_down,
  input wire logic timeout_flag,
  input wire logic warning_flag,
  input wire logic watchdog_event,
  input wire logic chip_reset_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_lock_tracks:
    assert property (clock_source_lock == run_enable_bit) else $error("lock mismatch");
  chk_run_holds:
    assert property (run_enable_bit |=> run_enable_bit) else $error("run enable fell");
  chk_rsten_holds:
    assert property (reset_on_timeout_enable |=> reset_on_timeout_enable)
      else $error("reset enable fell");
  chk_osc_kept:
    assert property (run_enable_bit |-> !osc_power_down) else $error("osc off while running");
  chk_mode_held:
    assert property (mode_wr && !feed_wr |=> $stable(run_enable_bit)
      && $stable(reset_on_timeout_enable)) else $error("mode applied without feed");
  chk_run_on_feed:
    assert property ($rose(run_enable_bit) |-> $past(feed_wr)) else $error("enable without feed");
  chk_event_reset:
    assert property (watchdog_event && reset_on_timeout_enable |-> chip_reset_req)
      else $error("no chip reset on event");
  chk_flag_on_event:
    assert property (watchdog_event |-> ##[0:1] timeout_flag) else $error("flag not set");
  chk_flag_sticky:
    assert property (disable iff (por_rst) timeout_flag && !timeout_flag_clear |=> timeout_flag)
      else $error("timeout flag lost");
  chk_event_enabled:
    assert property (watchdog_event |-> run_enable_bit) else $error("event while disabled");
  chk_warn_sticky:
    assert property (warning_flag && !warning_clear |=> warning_flag)
      else $error("warning flag lost");
endmodule // wdt_properties

bind windowed_watchdog_timer wdt_properties u_chk (
  .mclk                    (mclk),
  .rst                     (rst),
  .por_rst                 (por_rst),
  .mode_wr                 (mode_wr),
  .feed_wr                 (feed_wr),
  .timeout_flag_clear      (timeout_flag_clear),
  .warning_clear           (warning_clear),
  .run_enable_bit          (run_enable_bit),
  .reset_on_timeout_enable (reset_on_timeout_enable),
  .clock_source_lock       (clock_source_lock),
  .osc_power_down          (osc_power_down),
  .timeout_flag            (timeout_flag),
  .warning_flag            (warning_flag),
  .watchdog_event          (watchdog_event),
  .chip_reset_req          (chip_reset_req)
);
`default_nettype wire

// *** verif/tb_windowed_watchdog_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_windowed_watchdog_timer;
  logic        mclk = 0, rst = 1, por_rst = 1, count_clock = 0;
  logic        run_in = 0, rsten_in = 0, osc_req = 0, prot_in = 0;
  logic [7:0]  stb = 0;
  logic [23:0] d = 0, rl = 0;
  logic [31:0] seed = 32'hb4679f4b;
  int          checks = 0, n_mismatch = 0, cyc = 0;
  wire         run_en, rst_en, rprot, lock, osc_pd, tflag, wflag, ev, crr;
  wire [23:0]  rc, wc, wn, cnt;
  windowed_watchdog_timer dut (
    .mclk(mclk), .rst(rst), .por_rst(por_rst), .count_clock(count_clock),
    .mode_wr(stb[0]), .mode_run_enable_in(run_in), .mode_reset_en_in(rsten_in),
    .mode_protect_in(prot_in), .reload_wr(stb[1]), .reload_data(d), .feed_wr(stb[2]),
    .feed_data(d[7:0]), .window_wr(stb[3]), .window_data(d), .warning_wr(stb[4]),
    .warning_data(d), .readback_rd(stb[5]), .timeout_flag_clear(stb[6]),
    .warning_clear(stb[7]), .osc_power_down_req(osc_req), .run_enable_bit(run_en),
    .reset_on_timeout_enable(rst_en), .reload_protect(rprot), .clock_source_lock(lock),
    .osc_power_down(osc_pd), .timeout_flag(tflag), .warning_flag(wflag),
    .watchdog_event(ev), .chip_reset_req(crr), .reload_constant(rc),
    .window_compare(wc), .warning_compare(wn), .counter_readback(cnt));
  // =====================================================
  // clocks, helpers
  always #25 mclk = ~mclk;
  always #97 count_clock = ~count_clock;
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // value the counter starts from after a feed
  function logic [23:0] exp_load(input logic [23:0] v);
    return (v < 24'h0000ff) ? 24'h0000ff : v;
  endfunction
  task wr(input int k, input logic [23:0] v);
    @(negedge mclk);
    stb = 8'h1 << k;
    d = v;
  endtask
  task idle(input int n);
    repeat (n) begin @(negedge mclk); stb = 0; end
  endtask
  task feed;
    wr(2, 24'h0000aa); wr(2, 24'h000055); idle(1);
  endtask
  task wait_hi(input int k, input int n);
    int i;
    for (i = 0; i < n && (k ? wflag : ev) !== 1'b1; i++) @(posedge mclk) #1;
    `CHK(i < n, 1'b1)
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin n_mismatch++; report_and_stop; end
  end
  // =====================================================
  // scenarios
  initial begin
    repeat (6) @(negedge mclk);
    rst = 0; por_rst = 0;
    `CHK(rc, 24'h0000ff)
    `CHK(wc, 24'hffffff)
    `CHK(wn, 24'h000000)
    `CHK(cnt, 24'h0000ff)
    `CHK(tflag, 1'b0)
    `CHK(rprot, 1'b0)
    repeat (4) begin
      seed = lfsr(seed); osc_req = seed[9]; rl = {17'h0, seed[6:0]};
      wr(1, rl); idle(1);
      `CHK(rc, rl)
      `CHK(osc_pd, osc_req)
    end
    // reload first, then mode, then the enabling feed
    run_in = 1; rsten_in = 1; wr(0, 0); idle(2);
    `CHK(run_en, 1'b0)
    `CHK(lock, 1'b0)
    feed; idle(1);
    `CHK(run_en, 1'b1)
    `CHK(lock, 1'b1)
    `CHK(rst_en, 1'b1)
    osc_req = 1; idle(1);
    `CHK(osc_pd, 1'b0)
    `CHK(cnt, exp_load(rl))
    run_in = 0; rsten_in = 0; wr(0, 0); feed; idle(1);
    `CHK(run_en, 1'b1)
    `CHK(rst_en, 1'b1)
    wait_hi(0, 6000);
    `CHK(crr, 1'b1)
    idle(2);
    `CHK(tflag, 1'b1)
    wr(2, 24'h0000aa); wr(5, 0); idle(1);
    wait_hi(0, 5);
    `CHK(crr, 1'b1)
    wr(3, 24'h000080); idle(1);
    `CHK(wc, 24'h000080)
    feed;
    wait_hi(0, 5);
    // protected reload: refused until the warning value is reached
    prot_in = 1; wr(0, 0); wr(3, 24'hffffff); wr(4, 24'h0000f0); feed;
    wr(1, 24'h000100); idle(1);
    `CHK(rprot, 1'b1)
    `CHK(rc, rl)
    `CHK(wn, 24'h0000f0)
    wait_hi(1, 400);
    wr(7, 0); wr(1, 24'h000100); idle(1);
    `CHK(rc, 24'h000100)
    `CHK(wflag, 1'b0)
    rst = 1; idle(2); rst = 0; idle(1);
    `CHK(run_en, 1'b0)
    `CHK(tflag, 1'b1)
    `CHK(osc_pd, 1'b1)
    wr(6, 0); idle(2);
    `CHK(tflag, 1'b0)
    report_and_stop;
  end
endmodule // tb_windowed_watchdog_timer
`default_nettype wire
